// *** dv/xor_and_direction_load_exec_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module xor_and_direction_load_exec_tb
  import xor_exec_pkg::*;
;
  logic              clk = 0, rst = 1, iv = 0, fwe, zwe, zv, busy, done;
  logic [INSN_W-1:0] insn = '0;
  logic [ADDR_W-1:0] fa, ra;
  logic [DATA_W-1:0] frd = '0, fwd, acc, d5, d6, d7;
  int                n_errors = 0, checks_done = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  xor_and_direction_load_exec xor_and_direction_load_exec_i (.clk, .rst, .insn_valid(iv), .insn,
    .file_addr(fa), .file_rdata(frd), .file_we(fwe), .file_wdata(fwd), .zero_we(zwe),
    .zero_val(zv), .accum(acc), .dir_5(d5), .dir_6(d6), .dir_7(d7), .busy, .done);
  // Compare and count
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Offer one word, wait for done
  task automatic run(logic [INSN_W-1:0] w);
    int i;
    @(posedge clk) #1;
    iv = 1;
    insn = w;
    @(posedge clk) #1;
    iv = 0;
    ra = fa;
    chk("busy", 8'h01, {7'd0, busy});
    for (i = 0; i < 8 && done !== 1'b1; i++)
      @(posedge clk) #1;
    if (i == 8)
    begin
      n_errors++;
      $display("[FAIL] done exp 1 got %b", done);
      stop_test();
    end
    chk("cycles", 8'h03, i[7:0]);
    chk("busy", 8'h00, {7'd0, busy});
  endtask
  // Literal XOR, then a zero result
  task automatic t_lit;
    run({OP_XOR_LIT, 8'hb5});
    chk("acc", 8'hb5, acc);
    run({OP_XOR_LIT, 8'haf});
    chk("acc", 8'h1a, acc);
    chk("flags", 8'h02, {5'd0, fwe, zwe, zv});
    run({OP_XOR_LIT, 8'h1a});
    chk("flags", 8'h03, {5'd0, fwe, zwe, zv});
  endtask
  // File XOR to file, then to accumulator
  task automatic t_file;
    run({OP_XOR_LIT, 8'hb5});
    frd = 8'haf;
    run({OP_XOR_FILE, 1'b1, 7'h7f});
    chk("wdata", 8'h1a, fwd);
    chk("addr", 8'h7f, {1'b0, fa});
    chk("raddr", 8'h7f, {1'b0, ra});
    chk("acc", 8'hb5, acc);
    chk("flags", 8'h06, {5'd0, fwe, zwe, zv});
    run({OP_XOR_FILE, 1'b0, 7'h00});
    chk("acc", 8'h1a, acc);
    chk("raddr", 8'h00, {1'b0, ra});
    chk("flags", 8'h02, {5'd0, fwe, zwe, zv});
  endtask
  // Direction loads 7..5, then out-of-range 4..1
  task automatic t_dir;
    int p;
    logic [7:0] e;
    e = 8'h1a;
    for (p = 7; p > 0; p--)
    begin
      run({OP_XOR_LIT, e ^ p[7:0]});
      e = p[7:0];
      run({OP_DIR_HI, p[2:0]});
      chk("flags", 8'h00, {5'd0, fwe, zwe, zv});
      @(posedge clk) #1;
    end
    chk("d5", 8'h05, d5);
    chk("d6", 8'h06, d6);
    chk("d7", 8'h07, d7);
  endtask
  // Reset in mid-instruction, then a fresh literal XOR
  task automatic t_reset;
    @(posedge clk) #1;
    iv = 1;
    insn = {OP_XOR_LIT, 8'h3c};
    @(posedge clk) #1;
    iv = 0;
    rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    chk("acc", 8'h00, acc);
    chk("d5", 8'hff, d5);
    chk("flags", 8'h00, {5'd0, fwe, zwe, zv});
    chk("busy", 8'h00, {7'd0, busy});
    run({OP_XOR_LIT, 8'h3c});
    chk("acc", 8'h3c, acc);
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst = 0;
    chk("acc", 8'h00, acc);
    chk("d7", 8'hff, d7);
    t_lit();
    t_file();
    t_dir();
    t_reset();
    stop_test();
  end
endmodule // xor_and_direction_load_exec_tb
`default_nettype wire

// *** dv/xor_exec_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module xor_exec_assertions
  import xor_exec_pkg::*;
(
  // Clock, reset, handshake
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              insn_valid,
  input wire logic              busy,
  input wire logic              done,
  // Results
  input wire logic              file_we,
  input wire logic              zero_we,
  input wire logic              zero_val,
  input wire logic [DATA_W-1:0] file_wdata,
  input wire logic [DATA_W-1:0] accum,
  input wire logic [DATA_W-1:0] dir_5
);
  // Single domain
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_done_in_bound: assert property (insn_valid && !busy |-> ##[3:5] done) else $error("done late");
  a_done_one_cycle: assert property (done |=> !done) else $error("done too long");
  a_file_wr_done: assert property (file_we |-> done) else $error("file write off cycle");
  a_zero_file: assert property (zero_we && file_we |-> zero_val == (file_wdata == 8'h00)) else $error("z file");
  a_zero_accum: assert property (zero_we && !file_we |-> zero_val == (accum == 8'h00)) else $error("z accum");
  a_accum_cause: assert property ($changed(accum) |-> done) else $error("accum changed idle");
  a_dir_after: assert property ($changed(dir_5) |-> $past(done)) else $error("dir changed idle");
endmodule // xor_exec_assertions

bind xor_and_direction_load_exec xor_exec_assertions xor_exec_assertions_i (.clk, .rst, .insn_valid, .busy,
  .done, .file_we, .zero_we, .zero_val, .file_wdata, .accum, .dir_5);
`default_nettype wire

// *** rtl/port_dir_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
module port_dir_regs
  import xor_exec_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [1:0]        wr_idx,
  input  wire logic [DATA_W-1:0] wr_data,
  // Registered direction outputs
  output logic [DATA_W-1:0]      dir_0,
  output logic [DATA_W-1:0]      dir_1,
  output logic [DATA_W-1:0]      dir_2
);

  logic [DATA_W-1:0] mem_q [DIR_PORTS];

  // Direction register storage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < DIR_PORTS; i++) mem_q[i] <= DIR_RST;
    end
    else if (wr_en)
    begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  // Outputs
  assign dir_0 = mem_q[0];
  assign dir_1 = mem_q[1];
  assign dir_2 = mem_q[2];

endmodule // port_dir_regs
`default_nettype wire

// *** rtl/xor_and_direction_load_exec.sv ***
// Function
// - Literal XOR into accumulator, zero flag only
// - File XOR with accumulator, zero flag only
// - Destination bit picks accumulator or file
// - Four phases, one cycle, one word
`timescale 1ns/1ns
`default_nettype none
module xor_and_direction_load_exec
  import xor_exec_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Instruction from fetch
  input  wire logic              insn_valid,
  input  wire logic [INSN_W-1:0] insn,
  // File register read port
  output logic [ADDR_W-1:0]      file_addr,
  input  wire logic [DATA_W-1:0] file_rdata,
  // File register write port
  output logic                   file_we,
  output logic [DATA_W-1:0]      file_wdata,
  // Zero flag update
  output logic                   zero_we,
  output logic                   zero_val,
  // Architectural state
  output logic [DATA_W-1:0]      accum,
  output logic [DATA_W-1:0]      dir_5,
  output logic [DATA_W-1:0]      dir_6,
  output logic [DATA_W-1:0]      dir_7,
  // Status
  output logic                   busy,
  output logic                   done
);

  phase_e            phase_q, phase_d;
  logic [INSN_W-1:0] ir_q;
  logic [DATA_W-1:0] opnd_q, res_q, accum_q;
  logic              done_q, file_we_q, zero_we_q, zero_q, dir_we_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [1:0]        dir_idx_q;

  // Decode of held instruction
  wire logic is_lit  = ir_q[INSN_W-1:OP_LIT_POS] == OP_XOR_LIT;
  wire logic is_file = ir_q[INSN_W-1:OP_FILE_POS] == OP_XOR_FILE;
  wire logic [2:0] dir_sel = ir_q[2:0];
  wire logic is_dir  = (ir_q[INSN_W-1:DIR_HI_POS] == OP_DIR_HI)
                       && (dir_sel >= DIR_SEL_LO) && (dir_sel <= DIR_SEL_HI);
  wire logic to_file = ir_q[DEST_POS];
  wire logic [DATA_W-1:0] xor_res = accum_q ^ opnd_q;
  wire logic idle    = phase_q == PH_DECODE;
  wire logic take       = idle && insn_valid;
  wire logic in_read    = phase_q == PH_READ;
  wire logic in_process = phase_q == PH_PROCESS;
  wire logic in_write   = phase_q == PH_WRITE;

  // Operand source: literal field or file read data
  wire logic [DATA_W-1:0] opnd_d = is_lit ? ir_q[DATA_W-1:0] : file_rdata;

  // Write-phase destinations
  wire logic wr_accum = in_write && (is_lit || (is_file && !to_file));
  wire logic wr_file  = in_write && is_file && to_file;
  wire logic wr_zero  = in_write && (is_lit || is_file);
  wire logic wr_dir   = in_write && is_dir;

  // Phase sequencing, one instruction cycle
  always_comb
  begin
    unique case (phase_q)
      PH_DECODE:  phase_d = insn_valid ? PH_READ : PH_DECODE;
      PH_READ:    phase_d = PH_PROCESS;
      PH_PROCESS: phase_d = PH_WRITE;
      PH_WRITE:   phase_d = PH_DECODE;
    endcase
  end

  // Phase register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase_q <= PH_DECODE;
    end
    else
    begin
      phase_q <= phase_d;
    end
  end

  // Instruction capture while idle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ir_q <= '0;
    end
    else if (take)
    begin
      ir_q <= insn;
    end
  end

  // Read phase: operand capture
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      opnd_q <= '0;
    end
    else if (in_read)
    begin
      opnd_q <= opnd_d;
    end
  end

  // Process phase: exclusive-OR result
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      res_q <= '0;
    end
    else if (in_process)
    begin
      res_q <= xor_res;
    end
  end

  // Write phase: accumulator destination
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      accum_q <= ACCUM_RST;
    end
    else if (wr_accum)
    begin
      accum_q <= res_q;
    end
  end

  // Write phase: file write pulse with its address and data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      file_we_q <= 1'b0;
      addr_q    <= '0;
      wdata_q   <= '0;
    end
    else
    begin
      file_we_q <= wr_file;
      if (wr_file)
      begin
        addr_q  <= ir_q[ADDR_W-1:0];
        wdata_q <= res_q;
      end
    end
  end

  // Write phase: zero flag, the only status touched
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      zero_we_q <= 1'b0;
      zero_q    <= 1'b0;
    end
    else
    begin
      zero_we_q <= wr_zero;
      if (wr_zero)
      begin
        zero_q <= res_q == '0;
      end
    end
  end

  // Write phase: direction load request, index 0 is operand 5
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dir_we_q  <= 1'b0;
      dir_idx_q <= 2'h0;
    end
    else
    begin
      dir_we_q <= wr_dir;
      if (wr_dir)
      begin
        dir_idx_q <= 2'(dir_sel - DIR_SEL_LO);
      end
    end
  end

  // Completion pulse alongside the accumulator, file and flag writes and the direction load request
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= in_write;
    end
  end

  // Direction registers; no flag write here
  port_dir_regs u_dirs (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (dir_we_q),
    .wr_idx  (dir_idx_q),
    .wr_data (accum_q),
    .dir_0   (dir_5),
    .dir_1   (dir_6),
    .dir_2   (dir_7)
  );

  // Outputs
  assign file_addr  = file_we_q ? addr_q : ir_q[ADDR_W-1:0];
  assign file_we    = file_we_q;
  assign file_wdata = wdata_q;
  assign zero_we    = zero_we_q;
  assign zero_val   = zero_q;
  assign accum      = accum_q;
  assign busy       = !idle;
  assign done       = done_q;

endmodule // xor_and_direction_load_exec
`default_nettype wire

// *** rtl/xor_exec_pkg.sv ***
package xor_exec_pkg;

  // Instruction word and data widths
  localparam int unsigned INSN_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;

  // Opcode fields and values
  localparam int unsigned OP_LIT_POS  = 8;
  localparam int unsigned OP_FILE_POS = 8;
  localparam int unsigned DEST_POS    = 7;
  localparam logic [5:0] OP_XOR_LIT   = 6'h3a; // 11 1010
  localparam logic [5:0] OP_XOR_FILE  = 6'h06; // 00 0110
  localparam logic [10:0] OP_DIR_HI   = 11'h00c; // 00 0000 0110 0
  localparam int unsigned DIR_HI_POS  = 3;
  localparam logic [2:0] DIR_SEL_LO   = 3'h5;
  localparam logic [2:0] DIR_SEL_HI   = 3'h7;
  localparam int unsigned DIR_PORTS   = 3;

  // Reset values
  localparam logic [7:0] ACCUM_RST   = 8'h00;
  localparam logic [7:0] DIR_RST     = 8'hff;

  // Phase encoding of the instruction cycle
  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_e;

endpackage : xor_exec_pkg
